// ===== verilog/flash_cmd_map.vh
// Constants for the host-side flash command controller
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// Bus geometry
`define ADDR_W 19
`define DATA_W 8
`define SECTOR_W 3
`define SECTOR_LSB 16

// Command words, plain defaults for the parameters
`define UNLOCK1_ADDR 19'h00555
`define UNLOCK1_DATA 8'hAA
`define UNLOCK2_ADDR 19'h002AA
`define UNLOCK2_DATA 8'h55
`define ID_CMD_DATA 8'h90
`define RESET_CMD_DATA 8'hF0

// Identification read addresses
`define ID_ADDR_MAKER 19'h00000
`define ID_ADDR_PART 19'h00001
`define ID_ADDR_PROT 19'h00002
`define HV_ADDR_BIT 9
`define HV_A1_BIT 1
`define HV_A0_BIT 0

// Timing, in ns and derived cycles at the clock rate
`define CLK_MHZ 20
`define T_WP_NS 35
`define T_ACC_NS 70
`define CYC_OF(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define SYNC_CYC 2

// User operations
`define OP_W 3
`define OP_READ_ARRAY 3'h0
`define OP_ID_ENTER 3'h1
`define OP_ID_MAKER 3'h2
`define OP_ID_PART 3'h3
`define OP_ID_PROT 3'h4
`define OP_RESET 3'h5
`define OP_WRITE_RAW 3'h6
`define OP_HV_READ 3'h7

// Step indices within an operation
`define STEP_W 2
`define STEP_ID_READ 2'h3
`define STEP_ARRAY_READ 2'h1

`endif

// ===== verilog/flash_bus_cycle.v
// One timed read or write cycle on the flash pins
`timescale 1ns/100ps
`include "flash_cmd_map.vh"
module flash_bus_cycle #(
	parameter AW = `ADDR_W,
	parameter DW = `DATA_W,
	parameter WP_CYC = `CYC_OF(`T_WP_NS),
	parameter ACC_CYC = `CYC_OF(`T_ACC_NS)
) (
	// Clock and reset
	input wire clk,
	input wire resetn,
	// Cycle request
	input wire start,
	input wire wr,
	input wire hv,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output wire idle,
	output reg done_reg,
	output reg [DW-1:0] rdata_reg,
	// Flash pins
	output reg ce_n_reg,
	output reg oe_n_reg,
	output reg we_n_reg,
	output reg [AW-1:0] addr_pin_reg,
	output reg [DW-1:0] dq_out_reg,
	output reg dq_oe_n_reg,
	input wire [DW-1:0] dq_in,
	output reg id_hv_en_reg
);
	localparam S_IDLE = 4'h1;
	localparam S_SETUP = 4'h2;
	localparam S_STROBE = 4'h4;
	localparam S_HOLD = 4'h8;
	localparam integer WP_INT = WP_CYC;
	localparam integer RD_SUM = ACC_CYC + `SYNC_CYC;
	// Strobe counts always fit a byte, so the cut to eight bits is deliberate
	localparam [7:0] WP_LEN = WP_INT[7:0];
	localparam [7:0] RD_LEN = RD_SUM[7:0];

	reg [3:0] state_reg;
	reg [7:0] cnt_reg;
	reg wr_reg;
	reg [DW-1:0] dq_s1_reg;
	reg [DW-1:0] dq_s2_reg;

	assign idle = state_reg == S_IDLE;

	// Data pins pass two flops; only the second is ever sampled
	always @(posedge clk) begin
		dq_s1_reg <= dq_in;
		dq_s2_reg <= dq_s1_reg;
	end

	// Cycle sequencer: select first, strobe second, strobe released before select
	always @(posedge clk) begin
		if (!resetn) begin
			state_reg <= S_IDLE;
			cnt_reg <= 8'h00;
			wr_reg <= 1'b0;
			done_reg <= 1'b0;
			rdata_reg <= {DW{1'b0}};
			ce_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1; // strobes idle high out of reset
			addr_pin_reg <= {AW{1'b0}};
			dq_out_reg <= {DW{1'b0}};
			dq_oe_n_reg <= 1'b1;
			id_hv_en_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (start) begin
						wr_reg <= wr;
						addr_pin_reg <= addr;
						dq_out_reg <= wdata;
						dq_oe_n_reg <= ~wr;
						id_hv_en_reg <= hv;
						ce_n_reg <= 1'b0;
						state_reg <= S_SETUP;
					end
				end
				S_SETUP: begin
					// Write strobe falls after select, so its edge takes the address
					if (wr_reg) begin
						we_n_reg <= 1'b0; // output enable stays high
						cnt_reg <= WP_LEN - 8'h01;
					end else begin
						oe_n_reg <= 1'b0;
						cnt_reg <= RD_LEN - 8'h01;
					end
					state_reg <= S_STROBE;
				end
				S_STROBE: begin
					if (cnt_reg == 8'h00) begin
						// Write strobe rises first while data still driven
						we_n_reg <= 1'b1;
						oe_n_reg <= 1'b1;
						if (!wr_reg)
							rdata_reg <= dq_s2_reg;
						state_reg <= S_HOLD;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				S_HOLD: begin
					ce_n_reg <= 1'b1;
					dq_oe_n_reg <= 1'b1;
					id_hv_en_reg <= 1'b0;
					done_reg <= 1'b1;
					state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule // flash_bus_cycle

// ===== verilog/flash_cmd_autoselect_ctrl.v
// Host controller issuing identification, reset and raw cycles to a byte flash
`timescale 1ns/100ps
`include "flash_cmd_map.vh"
module flash_cmd_autoselect_ctrl #(
	parameter AW = `ADDR_W,
	parameter DW = `DATA_W,
	parameter [`ADDR_W-1:0] UNLOCK1_ADDR = `UNLOCK1_ADDR,
	parameter [`DATA_W-1:0] UNLOCK1_DATA = `UNLOCK1_DATA,
	parameter [`ADDR_W-1:0] UNLOCK2_ADDR = `UNLOCK2_ADDR,
	parameter [`DATA_W-1:0] UNLOCK2_DATA = `UNLOCK2_DATA,
	parameter [`DATA_W-1:0] ID_CMD_DATA = `ID_CMD_DATA,
	parameter [`DATA_W-1:0] RESET_CMD_DATA = `RESET_CMD_DATA
) (
	// Clock and reset
	input wire clk,
	input wire resetn,
	// Command port
	input wire cmd_valid,
	output wire cmd_ready,
	input wire [`OP_W-1:0] cmd_op,
	input wire [AW-1:0] cmd_addr,
	input wire [DW-1:0] cmd_data,
	input wire [`SECTOR_W-1:0] cmd_sector,
	input wire [1:0] cmd_hv_sel,
	// Answer
	output reg resp_valid_reg,
	output reg [DW-1:0] resp_data_reg,
	output reg resp_protected_reg,
	output reg id_mode_reg,
	// Supply state, high when above the lockout threshold
	input wire supply_ok,
	// Flash pins
	output wire ce_n,
	output wire oe_n,
	output wire we_n,
	output wire [AW-1:0] addr_pin,
	output wire [DW-1:0] byte_data_lines_out,
	output wire byte_data_lines_oe_n,
	input wire [DW-1:0] byte_data_lines_in,
	output wire id_hv_en
);
	localparam M_IDLE = 3'h1;
	localparam M_ISSUE = 3'h2;
	localparam M_WAIT = 3'h4;

	reg [2:0] state_reg;
	reg [`OP_W-1:0] op_reg;
	reg [AW-1:0] addr_reg;
	reg [DW-1:0] data_reg;
	reg [`SECTOR_W-1:0] sector_reg;
	reg [1:0] hv_sel_reg;
	reg [`STEP_W-1:0] step_reg;
	reg sup_s1_reg;
	reg sup_s2_reg;
	reg step_wr;
	reg step_hv;
	reg step_last;
	reg [AW-1:0] step_addr;
	reg [DW-1:0] step_data;
	wire cyc_idle;
	wire cyc_done;
	wire [DW-1:0] cyc_rdata;

	// Identification read address: sector in the top bits for the protection read only
	function [AW-1:0] id_addr;
		input [`OP_W-1:0] op;
		input [`SECTOR_W-1:0] sec;
		begin
			id_addr = `ID_ADDR_MAKER;
			if (op == `OP_ID_PART)
				id_addr = `ID_ADDR_PART;
			else if (op == `OP_ID_PROT) begin
				id_addr = `ID_ADDR_PROT;
				id_addr[AW-1:`SECTOR_LSB] = sec;
			end
		end
	endfunction

	// Supply level is asynchronous: two flops before use
	always @(posedge clk) begin
		sup_s1_reg <= supply_ok;
		sup_s2_reg <= sup_s1_reg;
	end

	// No command while the supply is low; the flash ignores writes then
	assign cmd_ready = (state_reg == M_IDLE) && sup_s2_reg && resetn;

	// Cycle content for the current step of the current operation
	always @* begin
		step_wr = 1'b1;
		step_hv = 1'b0;
		step_last = 1'b1;
		step_addr = {AW{1'b0}};
		step_data = RESET_CMD_DATA; // address bits left zero
		case (op_reg)
			`OP_ID_ENTER, `OP_ID_MAKER, `OP_ID_PART, `OP_ID_PROT: begin
				// Two unlock writes then the identification byte
				step_last = (op_reg == `OP_ID_ENTER) ? (step_reg == 2'h2) :
					(step_reg == `STEP_ID_READ);
				case (step_reg)
					2'h0: begin
						step_addr = UNLOCK1_ADDR;
						step_data = UNLOCK1_DATA;
					end
					2'h1: begin
						step_addr = UNLOCK2_ADDR;
						step_data = UNLOCK2_DATA;
					end
					2'h2: begin
						step_addr = UNLOCK1_ADDR;
						step_data = ID_CMD_DATA;
					end
					default: begin
						step_wr = 1'b0;
						step_addr = id_addr(op_reg, sector_reg);
					end
				endcase
			end
			`OP_READ_ARRAY: begin
				// Step 0 leaves identification mode first
				step_last = step_reg == `STEP_ARRAY_READ;
				if (step_reg == `STEP_ARRAY_READ) begin
					step_wr = 1'b0;
					step_addr = addr_reg;
				end
			end
			`OP_WRITE_RAW: begin
				step_addr = addr_reg;
				step_data = data_reg;
			end
			`OP_HV_READ: begin
				// High-voltage method: address pins pick the code
				step_wr = 1'b0;
				step_hv = 1'b1;
				step_addr = {AW{1'b0}};
				step_addr[AW-1:`SECTOR_LSB] = sector_reg;
				step_addr[`HV_A1_BIT] = hv_sel_reg[1];
				step_addr[`HV_A0_BIT] = hv_sel_reg[0];
			end
			default: begin
				step_addr = {AW{1'b0}};
			end
		endcase
	end

	// Operation sequencer
	always @(posedge clk) begin
		if (!resetn) begin
			state_reg <= M_IDLE;
			op_reg <= `OP_RESET;
			addr_reg <= {AW{1'b0}};
			data_reg <= {DW{1'b0}};
			sector_reg <= {`SECTOR_W{1'b0}};
			hv_sel_reg <= 2'h0;
			step_reg <= 2'h0;
			resp_valid_reg <= 1'b0;
			resp_data_reg <= {DW{1'b0}};
			resp_protected_reg <= 1'b0;
			id_mode_reg <= 1'b0; // flash powers up in array read
		end else begin
			resp_valid_reg <= 1'b0;
			case (state_reg)
				M_IDLE: begin
					if (cmd_valid && cmd_ready) begin
						op_reg <= cmd_op;
						addr_reg <= cmd_addr;
						data_reg <= cmd_data;
						sector_reg <= cmd_sector;
						hv_sel_reg <= cmd_hv_sel;
						// In identification mode reads need no new entry
						step_reg <= 2'h0;
						if (id_mode_reg && (cmd_op == `OP_ID_MAKER ||
							cmd_op == `OP_ID_PART || cmd_op == `OP_ID_PROT))
							step_reg <= `STEP_ID_READ;
						if (!id_mode_reg && cmd_op == `OP_READ_ARRAY)
							step_reg <= `STEP_ARRAY_READ;
						state_reg <= M_ISSUE;
					end
				end
				M_ISSUE: begin
					if (cyc_idle)
						state_reg <= M_WAIT;
				end
				M_WAIT: begin
					if (cyc_done) begin
						if (step_last) begin
							resp_valid_reg <= 1'b1;
							resp_data_reg <= step_wr ? step_data : cyc_rdata;
							resp_protected_reg <= !step_wr && cyc_rdata[0];
							case (op_reg)
								`OP_ID_ENTER, `OP_ID_MAKER, `OP_ID_PART, `OP_ID_PROT:
									id_mode_reg <= 1'b1;
								// Reset byte ends any mode or pending sequence
								`OP_RESET, `OP_READ_ARRAY:
									id_mode_reg <= 1'b0;
								`OP_WRITE_RAW:
									if (data_reg == RESET_CMD_DATA)
										id_mode_reg <= 1'b0;
								default:
									id_mode_reg <= id_mode_reg;
							endcase
							state_reg <= M_IDLE;
						end else begin
							step_reg <= step_reg + 2'h1;
							state_reg <= M_ISSUE;
						end
					end
				end
				default: state_reg <= M_IDLE;
			endcase
			// Lockout resets the flash command state; it must win over an entry
			// finishing in the same cycle, since the flash ignored those writes
			if (!sup_s2_reg)
				id_mode_reg <= 1'b0;
		end
	end

	// Pin cycle engine
	flash_bus_cycle #(
		.AW(AW),
		.DW(DW)
	) u_cycle (
		.clk(clk),
		.resetn(resetn),
		.start(state_reg == M_ISSUE),
		.wr(step_wr),
		.hv(step_hv),
		.addr(step_addr),
		.wdata(step_data),
		.idle(cyc_idle),
		.done_reg(cyc_done),
		.rdata_reg(cyc_rdata),
		.ce_n_reg(ce_n),
		.oe_n_reg(oe_n),
		.we_n_reg(we_n),
		.addr_pin_reg(addr_pin),
		.dq_out_reg(byte_data_lines_out),
		.dq_oe_n_reg(byte_data_lines_oe_n),
		.dq_in(byte_data_lines_in),
		.id_hv_en_reg(id_hv_en)
	);
endmodule // flash_cmd_autoselect_ctrl

// ===== test/flash_cmd_checker.sv
// Pin-level checks on the host flash controller
`timescale 1ns/100ps
`include "flash_cmd_map.vh"
module flash_cmd_checker #(
	parameter [7:0] RST_B = 8'hF0
) (
	input wire clk,
	input wire resetn,
	input wire cmd_ready,
	input wire supply_ok,
	input wire id_mode_reg,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire id_hv_en,
	input wire byte_data_lines_oe_n,
	input wire [`ADDR_W-1:0] addr_pin,
	input wire [`DATA_W-1:0] byte_data_lines_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// A write pulse is one cycle of low strobe
	sequence s_wr_pulse;
		$fell(we_n) ##1 $rose(we_n);
	endsequence
	a_write_gating: assert property ($fell(we_n) |-> oe_n && !ce_n)
		else $error("write strobe not gated");
	a_no_contention: assert property (!oe_n |-> we_n && byte_data_lines_oe_n)
		else $error("read overlaps write");
	a_wr_pulse_len: assert property ($fell(we_n) |-> s_wr_pulse)
		else $error("write pulse length");
	a_addr_held: assert property (!ce_n && $past(!ce_n) |-> $stable(addr_pin))
		else $error("address moved under select");
	a_data_held: assert property ($rose(we_n) |-> !ce_n && !byte_data_lines_oe_n
		&& $stable(byte_data_lines_out))
		else $error("data not held at strobe rise");
	a_lockout_block: assert property (!supply_ok [*5] |-> !cmd_ready && !id_mode_reg)
		else $error("activity under lockout");
	a_reset_exits: assert property ($rose(we_n) && byte_data_lines_out == RST_B
		|-> ##[1:16] !id_mode_reg)
		else $error("reset byte kept id mode");
	a_hv_read_only: assert property (id_hv_en |-> we_n)
		else $error("write under high voltage");
endmodule // flash_cmd_checker

bind flash_cmd_autoselect_ctrl flash_cmd_checker #(.RST_B(RESET_CMD_DATA)) u_chk (.*);

// ===== test/flash_model.sv
// Behavioural byte flash answering the host controller
`timescale 1ns/100ps
`include "flash_cmd_map.vh"
module flash_model #(
	parameter [7:0] MAKER_CODE = 8'hC3, // arbitrary value
	parameter [7:0] PART_CODE = 8'h3C, // arbitrary value
	parameter [7:0] PROT_MASK = 8'h00
) (
	// Strobes and address
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire id_hv_en,
	input wire supply_ok,
	input wire [18:0] addr_pin,
	// Data lines
	input wire [7:0] dq_wr,
	output reg [7:0] dq_rd
);
	reg [1:0] seq_reg = 2'h0;
	reg id_mode_reg = 1'b0;
	reg armed_reg = 1'b0;
	reg [18:0] a_reg;
	wire wr_act = armed_reg && !ce_n && !we_n && oe_n;
	wire [2:0] sec = addr_pin[18:16];
	// Strobes found low at power-up must rise before a write counts
	always @(ce_n, we_n) if (ce_n || we_n) armed_reg = 1'b1;
	// Address on the later fall, data on the earlier rise
	always @(posedge wr_act) a_reg = addr_pin;
	always @(negedge wr_act) begin
		if (!supply_ok) begin
		end else if (dq_wr == `RESET_CMD_DATA) begin
			seq_reg = 2'h0;
			id_mode_reg = 1'b0;
		end else if (!id_mode_reg) begin
			if (seq_reg == 2'h2 && dq_wr == `ID_CMD_DATA) id_mode_reg = 1'b1;
			if (seq_reg == 2'h0 && a_reg == `UNLOCK1_ADDR && dq_wr == `UNLOCK1_DATA)
				seq_reg = 2'h1;
			else if (seq_reg == 2'h1 && a_reg == `UNLOCK2_ADDR && dq_wr == `UNLOCK2_DATA)
				seq_reg = 2'h2;
			else
				seq_reg = 2'h0;
		end
	end
	// Lockout drops all command state
	always @(negedge supply_ok) begin
		seq_reg = 2'h0;
		id_mode_reg = 1'b0;
	end
	// Released lines flip on every change so stale data never passes
	always @(ce_n, oe_n, id_hv_en, id_mode_reg, addr_pin) begin
		if (ce_n || oe_n)
			dq_rd = ~dq_rd;
		else if (id_hv_en || id_mode_reg)
			case (addr_pin[1:0])
				2'h0: dq_rd = MAKER_CODE;
				2'h1: dq_rd = PART_CODE;
				2'h2: dq_rd = {7'h00, PROT_MASK[sec]};
				default: dq_rd = 8'h00;
			endcase
		else
			dq_rd = addr_pin[7:0] ^ 8'hA5;
	end
endmodule // flash_model

// ===== test/tb_top.sv
// Self-checking bench for the host flash controller
`timescale 1ns/100ps
`include "flash_cmd_map.vh"
module tb_top;
	localparam [7:0] MAKER = 8'hC3; // arbitrary value
	localparam [7:0] PART = 8'h3C; // arbitrary value
	localparam [7:0] PROT = 8'h29;
	reg clk = 1'b0;
	reg resetn = 1'b0;
	reg cmd_valid = 1'b0;
	reg [2:0] cmd_op = 3'h0;
	reg [18:0] cmd_addr = 19'h00000;
	reg [7:0] cmd_data = 8'h00;
	reg [2:0] cmd_sector = 3'h0;
	reg [1:0] cmd_hv_sel = 2'h0;
	reg supply_ok = 1'b1;
	wire cmd_ready, resp_valid_reg, resp_protected_reg, id_mode_reg;
	wire ce_n, oe_n, we_n, dq_oe_n, id_hv_en;
	wire [18:0] addr_pin;
	wire [7:0] resp_data_reg, dq_out, dq_rd;
	wire [7:0] dq_in = dq_oe_n ? dq_rd : dq_out; // Wire level from both drivers
	integer err_total = 0;
	integer tests_run = 0;
	integer i;
	always #25 clk = ~clk;
	flash_cmd_autoselect_ctrl u_dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.cmd_sector(cmd_sector), .cmd_hv_sel(cmd_hv_sel), .resp_valid_reg(resp_valid_reg),
		.resp_data_reg(resp_data_reg), .resp_protected_reg(resp_protected_reg),
		.id_mode_reg(id_mode_reg), .supply_ok(supply_ok), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .addr_pin(addr_pin), .byte_data_lines_out(dq_out),
		.byte_data_lines_oe_n(dq_oe_n), .byte_data_lines_in(dq_in), .id_hv_en(id_hv_en));
	flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .PROT_MASK(PROT)) u_flash (
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .id_hv_en(id_hv_en), .supply_ok(supply_ok),
		.addr_pin(addr_pin), .dq_wr(dq_out), .dq_rd(dq_rd));
	task check(input [7:0] seen, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("errors %0d checks %0d", err_total, tests_run);
			if (err_total == 0 && tests_run > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// One request held until taken, then a bounded wait for the answer
	task run_op(input [2:0] op, input [18:0] a, input [7:0] d, input [2:0] s, input [1:0] h);
		integer n;
		begin
			cmd_valid <= 1'b1;
			cmd_op <= op;
			cmd_addr <= a;
			cmd_data <= d;
			cmd_sector <= s;
			cmd_hv_sel <= h;
			n = 0;
			@(posedge clk);
			while (cmd_ready !== 1'b1 && n < 80) begin
				@(posedge clk);
				n = n + 1;
			end
			if (n >= 80) begin
				err_total = err_total + 1;
				$display("BAD %0t request not taken", $time);
			end
			cmd_valid <= 1'b0;
			n = 0;
			@(posedge clk);
			while (resp_valid_reg !== 1'b1 && n < 80) begin
				@(posedge clk);
				n = n + 1;
			end
			if (n >= 80) begin
				err_total = err_total + 1;
				$display("BAD %0t no answer", $time);
			end
		end
	endtask
	// Plain reads after power-up, top address included
	task t_array;
		begin
			run_op(`OP_READ_ARRAY, 19'h7FFFF, 8'h00, 3'h0, 2'h0);
			check(resp_data_reg, 8'hFF ^ 8'hA5);
			run_op(`OP_READ_ARRAY, 19'h10203, 8'h00, 3'h0, 2'h0);
			check(resp_data_reg, 8'h03 ^ 8'hA5);
		end
	endtask
	// Enter by command, then repeated code reads and every sector
	task t_id;
		begin
			run_op(`OP_ID_ENTER, 19'h00000, 8'h00, 3'h0, 2'h0);
			check(u_flash.id_mode_reg, 8'h01);
			for (i = 0; i < 2; i = i + 1) begin
				run_op(`OP_ID_MAKER, 19'h00000, 8'h00, 3'h0, 2'h0);
				check(resp_data_reg, MAKER);
				run_op(`OP_ID_PART, 19'h00000, 8'h00, 3'h0, 2'h0);
				check(resp_data_reg, PART);
			end
			for (i = 0; i < 8; i = i + 1) begin
				run_op(`OP_ID_PROT, 19'h00000, 8'h00, i[2:0], 2'h0);
				check(resp_protected_reg, PROT[i]);
			end
			check(id_mode_reg, 8'h01);
			run_op(`OP_READ_ARRAY, 19'h12345, 8'h00, 3'h0, 2'h0);
			check(resp_data_reg, 8'h45 ^ 8'hA5);
			check(u_flash.id_mode_reg, 8'h00);
		end
	endtask
	// Reset byte after both unlock cycles, odd address, then recovery
	task t_abort;
		begin
			run_op(`OP_WRITE_RAW, `UNLOCK1_ADDR, `UNLOCK1_DATA, 3'h0, 2'h0);
			run_op(`OP_WRITE_RAW, `UNLOCK2_ADDR, `UNLOCK2_DATA, 3'h0, 2'h0);
			run_op(`OP_WRITE_RAW, 19'h7ABCD, `RESET_CMD_DATA, 3'h0, 2'h0);
			check(u_flash.seq_reg, 8'h00);
			run_op(`OP_WRITE_RAW, `UNLOCK1_ADDR, `ID_CMD_DATA, 3'h0, 2'h0);
			check(u_flash.id_mode_reg, 8'h00);
			check(id_mode_reg, 8'h00);
			run_op(`OP_ID_PART, 19'h00000, 8'h00, 3'h0, 2'h0);
			check(resp_data_reg, PART);
			run_op(`OP_RESET, 19'h00000, 8'h00, 3'h0, 2'h0);
			check(u_flash.id_mode_reg, 8'h00);
		end
	endtask
	// High-voltage selection by A1/A0 and sector
	task t_hv;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				run_op(`OP_HV_READ, 19'h00000, 8'h00, i[2:0], (i < 2) ? i[1:0] : 2'h2);
				check(resp_data_reg, (i == 0) ? MAKER : (i == 1) ? PART : {7'h00, PROT[i]});
			end
			check(u_flash.id_mode_reg, 8'h00);
		end
	endtask
	// Supply drop in id mode clears state and stops requests
	task t_lockout;
		begin
			run_op(`OP_ID_ENTER, 19'h00000, 8'h00, 3'h0, 2'h0);
			supply_ok <= 1'b0;
			repeat (6) @(posedge clk);
			check(cmd_ready, 8'h00);
			check(id_mode_reg, 8'h00);
			supply_ok <= 1'b1;
			repeat (4) @(posedge clk);
			run_op(`OP_READ_ARRAY, 19'h00055, 8'h00, 3'h0, 2'h0);
			check(resp_data_reg, 8'h55 ^ 8'hA5);
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		t_array;
		t_id;
		t_abort;
		t_hv;
		t_lockout;
		give_verdict;
	end
	// Watchdog far beyond the few hundred cycles the run needs
	initial begin
		#1000000;
		err_total = err_total + 1;
		give_verdict;
	end
endmodule // tb_top
